// >>> memory_hub_control_regs_tb.sv
// self-checking bench for the memory hub control register bank
`default_nettype none

module memory_hub_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mhc_pkg::*;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        spd_read_done, spd_write_done, spd_error, phase_flag;
    logic [7:0]  spd_read_byte;
    logic        cha_en, chb_en, ext_sel, a_stop_n, b_stop_n, a_pd_n, b_pd_n;
    logic [6:0]  up_drv, a_drv, b_drv;
    int          n_fail, n_checks;

    mhc_host host (.hclk(hclk), .hresetn(hresetn), .hready(hreadyout), .hrdata(hrdata),
                   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
                   .hsize(hsize), .hwdata(hwdata));

    mhc_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .spd_read_done(spd_read_done), .spd_read_byte(spd_read_byte),
        .spd_write_done(spd_write_done), .spd_error(spd_error),
        .upstream_clock_phase_flag(phase_flag), .first_channel_enable(cha_en),
        .second_channel_enable(chb_en), .upstream_drive(up_drv),
        .first_channel_drive(a_drv), .second_channel_drive(b_drv),
        .external_clock_select(ext_sel), .first_gen_stop_n(a_stop_n),
        .second_gen_stop_n(b_stop_n), .first_gen_powerdown_n(a_pd_n),
        .second_gen_powerdown_n(b_pd_n));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        host.xfer(a, 1'b1, d, r);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        host.xfer(a, 1'b0, 32'h0, r);
    endtask

    task automatic ev(input logic [2:0] k, input logic [7:0] b);
        @(posedge hclk);
        {spd_read_done, spd_write_done, spd_error} <= k;
        spd_read_byte <= b;
        @(posedge hclk);
        {spd_read_done, spd_write_done, spd_error} <= 3'b000;
    endtask

    function automatic logic [31:0] pins();
        return {27'h0, b_stop_n, b_pd_n, a_stop_n, a_pd_n, ext_sel};
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] r;
        foreach (CTRL_SEL[i]) begin
            rd(ba(8'h04 + 8'(2 * i)), r);
            check("ctrl reset", r, 32'h0);
        end
        rd(ba(IDX_MAILBOX), r);
        check("mailbox reset", r, 32'h0);
        rd(ba(IDX_CLOCK), r);
        check("clock reset", r, 32'h0);
        check("clock pins reset", pins(), 32'h0);
        check("enables reset", {30'h0, chb_en, cha_en}, 32'h0);
    endtask

    task automatic t_upstream;
        logic [31:0] r;
        wr(ba(IDX_UPSTREAM), 32'hffff_f955);
        rd(ba(IDX_UPSTREAM), r);
        check("upstream read", r, 32'h0000_0055);
        check("upstream drive", {25'h0, up_drv}, 32'h55);
        check("enables off", {30'h0, chb_en, cha_en}, 32'h0);
        wr(ba(IDX_UPSTREAM), 32'hffff_ffff);
        rd(ba(IDX_UPSTREAM), r);
        check("upstream read", r, {16'h0, MASK_UP});
        check("enables on", {30'h0, chb_en, cha_en}, 32'h3);
        check("upstream drive", {25'h0, up_drv}, 32'h7f);
    endtask

    task automatic t_drive;
        logic [31:0] r;
        wr(ba(IDX_FIRST), 32'hffff_ffaa);
        wr(ba(IDX_SECOND), 32'h0000_ff81);
        rd(ba(IDX_FIRST), r);
        check("first read", r, 32'h2a);
        rd(ba(IDX_SECOND), r);
        check("second read", r, 32'h01);
        check("first drive", {25'h0, a_drv}, 32'h2a);
        check("second drive", {25'h0, b_drv}, 32'h01);
    endtask

    task automatic t_clock;
        logic [31:0] r;
        for (int i = 1; i < 6; i++) begin
            wr(ba(IDX_CLOCK), 32'h1 << i);
            check("clock pins", pins(), 32'h1 << (i - 1));
            rd(ba(IDX_CLOCK), r);
            check("clock read", r, 32'h1 << i);
        end
        wr(ba(IDX_CLOCK), 32'hffff_ffff);
        @(posedge hclk);
        phase_flag <= 1'b1;
        repeat (3) @(posedge hclk);
        rd(ba(IDX_CLOCK), r);
        check("phase high", r, 32'h3f);
        @(posedge hclk);
        phase_flag <= 1'b0;
        repeat (3) @(posedge hclk);
        rd(ba(IDX_CLOCK), r);
        check("phase low", r, {16'h0, MASK_CLOCK});
    endtask

    task automatic t_mailbox;
        logic [31:0] r;
        for (int i = 0; i < 3; i++) begin
            ev(3'b100 >> i, 8'h3c);
            rd(ba(IDX_MAILBOX), r);
            check("mailbox flag", r & 32'hffff_e000, 32'h8000 >> i);
            if (i == 0) check("mailbox byte", r, 32'h803c);
            rd(ba(IDX_MAILBOX), r);
            check("flag cleared", r & 32'hffff_e000, 32'h0);
        end
        ev(3'b100, 8'ha5);
        wr(ba(IDX_MAILBOX), 32'hffff_ffff);
        rd(ba(IDX_MAILBOX), r);
        check("flag vs write", r & 32'hffff_ff00, 32'h8000);
        rd(ba(IDX_MAILBOX), r);
        check("flags readonly", r & 32'hffff_ff00, 32'h0);
    endtask

    task automatic t_unmapped;
        logic [31:0] r;
        wr(ba(8'h05), 32'hffff_ffff);
        rd(ba(8'h05), r);
        check("unmapped read", r, 32'h0);
        wr(32'h0000_0410, 32'h0);
        rd(32'h0000_0410, r);
        check("alias read", r, 32'h0);
        rd(ba(IDX_UPSTREAM), r);
        check("alias no write", r, {16'h0, MASK_UP});
    endtask

    task automatic t_async_reset;
        logic [31:0] r;
        @(posedge hclk);
        hresetn <= 1'b0;
        #1;
        // taken before any further rising edge, so only an asynchronous clear passes
        check("async pins", pins(), 32'h0);
        check("async ctrl", {up_drv, a_drv, b_drv, chb_en, cha_en}, 32'h0);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(ba(IDX_UPSTREAM), r);
        check("after reset", r, 32'h0);
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        #200000;
        n_fail++;
        summarize();
    end

    initial begin
        n_fail = 0;
        n_checks = 0;
        hresetn = 1'b0;
        {spd_read_done, spd_write_done, spd_error, phase_flag} = 4'h0;
        spd_read_byte = 8'h00;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_upstream();
        t_drive();
        t_clock();
        t_mailbox();
        t_unmapped();
        t_async_reset();
        summarize();
    end
endmodule

`default_nettype wire

// >>> mhc_host.sv
// upstream controller model: single-word ahb-lite master driven by tasks
`default_nettype none

module mhc_host (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import mhc_pkg::*;

    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b010;
        hwdata = 32'h0;
    end

    // ------------------------------------------------------------
    // single-word transfers
    // ------------------------------------------------------------
    // on waking at an edge the old level is seen, which is what that edge samples
    task automatic wait_ready;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsize  <= 3'b010;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? wd : 32'h0;
        wait_ready();
        rd = hrdata;
    endtask
endmodule

`default_nettype wire

// >>> mhc_mailbox.sv
// presence-detect mailbox: sticky done/error flags and fetched byte
`default_nettype none

module mhc_mailbox (
    input  wire logic  hclk,
    input  wire logic  hresetn,
    mhc_mbox_if.mbox   mb
);
    import mhc_pkg::*;

    logic       rvalid;
    logic       wdone;
    logic       err;
    logic [7:0] data_byte;

    // ------------------------------------------------------------
    // flags: a set in the clearing cycle wins
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rvalid <= 1'b0;
        end else if (mb.rd_done) begin
            rvalid <= 1'b1;
        end else if (mb.clr) begin
            rvalid <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdone <= 1'b0;
        end else if (mb.wr_done) begin
            wdone <= 1'b1;
        end else if (mb.clr) begin
            wdone <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err <= 1'b0;
        end else if (mb.err) begin
            err <= 1'b1;
        end else if (mb.clr) begin
            err <= 1'b0;
        end
    end

    // fetched byte beats a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_byte <= RST_MB_BYTE;
        end else if (mb.rd_done) begin
            data_byte <= mb.rd_byte;
        end else if (mb.sw_we) begin
            data_byte <= mb.sw_byte;
        end
    end

    assign mb.status = {rvalid, wdone, err, 5'h00, data_byte};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_rvalid_set: assert property (@(posedge hclk) disable iff (!hresetn)
        mb.rd_done |=> mb.status[BIT_RVALID] && mb.status[7:0] == $past(mb.rd_byte))
        else $error("read-valid flag or byte not loaded");
    chk_wdone_set: assert property (@(posedge hclk) disable iff (!hresetn)
        mb.wr_done |=> mb.status[BIT_WDONE])
        else $error("write-done flag not set");
    chk_err_set: assert property (@(posedge hclk) disable iff (!hresetn)
        mb.err |=> mb.status[BIT_ERR])
        else $error("error flag not set");
    chk_flags_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        mb.clr && !mb.rd_done && !mb.wr_done && !mb.err |=> mb.status[15:13] == 3'b000)
        else $error("flags not cleared by read");
endmodule

`default_nettype wire

// >>> mhc_mbox_if.sv
// link between the register decoder and the presence-detect mailbox
`default_nettype none

interface mhc_mbox_if;
    logic        rd_done;
    logic [7:0]  rd_byte;
    logic        wr_done;
    logic        err;
    logic        clr;
    logic        sw_we;
    logic [7:0]  sw_byte;
    logic [15:0] status;

    modport ctrl (output rd_done, rd_byte, wr_done, err, clr, sw_we, sw_byte, input status);
    modport mbox (input rd_done, rd_byte, wr_done, err, clr, sw_we, sw_byte, output status);
endinterface

`default_nettype wire

// >>> mhc_pkg.sv
// constants and types shared by the memory hub control register bank
`default_nettype none

package mhc_pkg;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_UPSTREAM = 8'h04;
    localparam logic [7:0] IDX_FIRST    = 8'h06;
    localparam logic [7:0] IDX_SECOND   = 8'h08;
    localparam logic [7:0] IDX_MAILBOX  = 8'h0a;
    localparam logic [7:0] IDX_CLOCK    = 8'h0b;

    localparam int unsigned REG_W  = 16;
    localparam int unsigned DATA_W = 32;

    // ------------------------------------------------------------
    // reset values and write masks
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CTRL     = 16'h0000;
    localparam logic [15:0] RST_CLOCK    = 16'h0000;
    localparam logic [7:0]  RST_MB_BYTE  = 8'h00;
    localparam logic [15:0] MASK_UP      = 16'h067f;
    localparam logic [15:0] MASK_DRIVE   = 16'h007f;
    localparam logic [15:0] MASK_CLOCK   = 16'h003e;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned DRIVE_MAX_W  = 7;
    localparam int unsigned BIT_CHA_EN   = 9;
    localparam int unsigned BIT_CHB_EN   = 10;
    localparam int unsigned BIT_RVALID   = 15;
    localparam int unsigned BIT_WDONE    = 14;
    localparam int unsigned BIT_ERR      = 13;
    localparam int unsigned BIT_B_STOP   = 5;
    localparam int unsigned BIT_B_PWRDN  = 4;
    localparam int unsigned BIT_A_STOP   = 3;
    localparam int unsigned BIT_A_PWRDN  = 2;
    localparam int unsigned BIT_EXT_CLK  = 1;
    localparam int unsigned BIT_PHASE    = 0;

    // ------------------------------------------------------------
    // bus encodings and types
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [2:0] {
        SEL_UP      = 3'b000,
        SEL_FIRST   = 3'b001,
        SEL_SECOND  = 3'b010,
        SEL_MAILBOX = 3'b011,
        SEL_CLOCK   = 3'b100,
        SEL_NONE    = 3'b111
    } mhc_sel_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_DATA = 1'b1
    } mhc_state_t;

    localparam mhc_sel_t    CTRL_SEL  [3] = '{SEL_UP, SEL_FIRST, SEL_SECOND};
    localparam logic [15:0] CTRL_MASK [3] = '{MASK_UP, MASK_DRIVE, MASK_DRIVE};

endpackage

`default_nettype wire

// >>> mhc_regs.sv
// memory hub control register bank behind an AHB-Lite slave
//
// Contract
// - channel-two enable low keeps channel two off
// - channel-one enable low keeps channel one off
// - bits 6:0 set upstream data drive current
// - bits 6:0 set first channel drive current
// - bits 6:0 set second channel drive current
// - mailbox bit 15 marks read byte, read clears
// - mailbox bit 14 marks write done, read clears
// - mailbox bit 13 marks bus failure, read clears
// - mailbox low byte holds fetched EEPROM byte
// - clock bit 5 drives second stop pin
// - clock bit 3 drives first stop pin
// - clock bits 4,2 drive powerdown pins, reset low
// - clock bit 1 selects external channel clocks
// - clock bit 0 reports upstream clock phase
// - system reset asynchronously restores all defaults
//
// The AHB-Lite register port is this design's own decision.
`default_nettype none

module mhc_regs #(
    parameter int unsigned DRIVE_W = 7
) (
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [mhc_pkg::DATA_W-1:0] hwdata,
    input  wire logic                       hready,
    output logic      [mhc_pkg::DATA_W-1:0] hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    input  wire logic                       spd_read_done,
    input  wire logic [7:0]                 spd_read_byte,
    input  wire logic                       spd_write_done,
    input  wire logic                       spd_error,
    input  wire logic                       upstream_clock_phase_flag,
    output logic                            first_channel_enable,
    output logic                            second_channel_enable,
    output logic      [DRIVE_W-1:0]         upstream_drive,
    output logic      [DRIVE_W-1:0]         first_channel_drive,
    output logic      [DRIVE_W-1:0]         second_channel_drive,
    output logic                            external_clock_select,
    output logic                            first_gen_stop_n,
    output logic                            second_gen_stop_n,
    output logic                            first_gen_powerdown_n,
    output logic                            second_gen_powerdown_n
);
    import mhc_pkg::*;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    // drive fields must fit below the reserved bits at 7 and up
    if (DRIVE_W < 1 || DRIVE_W > DRIVE_MAX_W) begin : g_bad_width
        $error("DRIVE_W must be 1 to 7");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    mhc_state_t        state;
    mhc_state_t        next_state;
    mhc_sel_t          dsel;
    logic              dwrite;
    logic              addr_take;
    logic              wr_fire;
    logic              rd_fire;
    logic [REG_W-1:0]  ctl [3];
    logic [REG_W-1:0]  clk_ctl;
    logic [REG_W-1:0]  rd_word;
    logic              ph_meta;
    logic              ph_sync;

    // the mailbox keeps its own set-beats-clear flags behind this link
    mhc_mbox_if mb ();

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // hsize is not looked at: every access is one whole word
    // only whole aligned words inside the low kilobyte are mapped
    function automatic mhc_sel_t decode(input logic [31:0] a);
        mhc_sel_t s;
        s = SEL_NONE;
        if (a[1:0] == 2'b00 && a[31:10] == 22'h000000) begin
            case (a[9:2])
                IDX_UPSTREAM: s = SEL_UP;
                IDX_FIRST:    s = SEL_FIRST;
                IDX_SECOND:   s = SEL_SECOND;
                IDX_MAILBOX:  s = SEL_MAILBOX;
                IDX_CLOCK:    s = SEL_CLOCK;
                default:      s = SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // ------------------------------------------------------------
    // bus slave sequencing
    // ------------------------------------------------------------
    assign addr_take = hsel && hready && htrans[1] && (state == ST_IDLE);
    assign wr_fire   = (state == ST_DATA) && dwrite;
    assign rd_fire   = (state == ST_DATA) && !dwrite;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (addr_take) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // one wait cycle so read data can come from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else if (state == ST_IDLE) begin
            hreadyout <= !addr_take;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dsel   <= SEL_NONE;
            dwrite <= 1'b0;
        end else if (addr_take) begin
            dsel   <= decode(haddr);
            dwrite <= hwrite;
        end
    end

    // every transfer completes without error
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= HRESP_OKAY;
        end else begin
            hresp <= HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------
    // enable and drive current registers
    // ------------------------------------------------------------
    for (genvar i = 0; i < 3; i++) begin : g_ctl
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ctl[i] <= RST_CTRL;
            end else if (wr_fire && dsel == CTRL_SEL[i]) begin
                ctl[i] <= hwdata[REG_W-1:0] & CTRL_MASK[i];
            end
        end
    end

    assign upstream_drive        = ctl[0][DRIVE_W-1:0];
    assign first_channel_drive   = ctl[1][DRIVE_W-1:0];
    assign second_channel_drive  = ctl[2][DRIVE_W-1:0];
    // channel logic gates its power and DLLs from these levels
    assign first_channel_enable  = ctl[0][BIT_CHA_EN];
    assign second_channel_enable = ctl[0][BIT_CHB_EN];

    // ------------------------------------------------------------
    // clock generator control
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_ctl <= RST_CLOCK;
        end else if (wr_fire && dsel == SEL_CLOCK) begin
            clk_ctl <= hwdata[REG_W-1:0] & MASK_CLOCK;
        end
    end

    // pins are the register bits themselves, no gating
    assign second_gen_stop_n      = clk_ctl[BIT_B_STOP];
    assign first_gen_stop_n       = clk_ctl[BIT_A_STOP];
    assign second_gen_powerdown_n = clk_ctl[BIT_B_PWRDN];
    assign first_gen_powerdown_n  = clk_ctl[BIT_A_PWRDN];
    assign external_clock_select  = clk_ctl[BIT_EXT_CLK];

    // phase flag comes from the link clocks, so synchronise it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_meta <= 1'b0;
            ph_sync <= 1'b0;
        end else begin
            ph_meta <= upstream_clock_phase_flag;
            ph_sync <= ph_meta;
        end
    end

    // ------------------------------------------------------------
    // mailbox
    // ------------------------------------------------------------
    assign mb.rd_done = spd_read_done;
    assign mb.rd_byte = spd_read_byte;
    assign mb.wr_done = spd_write_done;
    assign mb.err     = spd_error;
    assign mb.clr     = rd_fire && dsel == SEL_MAILBOX;
    assign mb.sw_we   = wr_fire && dsel == SEL_MAILBOX;
    assign mb.sw_byte = hwdata[7:0];

    mhc_mailbox u_mailbox (
        .hclk    (hclk),
        .hresetn (hresetn),
        .mb      (mb.mbox)
    );

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 16'h0000;
        case (dsel)
            SEL_UP:      rd_word = ctl[0];
            SEL_FIRST:   rd_word = ctl[1];
            SEL_SECOND:  rd_word = ctl[2];
            SEL_MAILBOX: rd_word = mb.status;
            SEL_CLOCK:   rd_word = {clk_ctl[REG_W-1:1], ph_sync};
            default:     rd_word = 16'h0000;
        endcase
    end

    // status is sampled at the same edge that clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_fire) begin
            hrdata <= {16'h0000, rd_word};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_bus_wait: assert property (
        addr_take |=> !hreadyout ##1 hreadyout)
        else $error("slave did not answer after one wait");
    chk_up_drive: assert property (
        wr_fire && dsel == SEL_UP |=> upstream_drive == $past(hwdata[DRIVE_W-1:0]))
        else $error("upstream drive not updated");
    chk_first_drive: assert property (
        wr_fire && dsel == SEL_FIRST
        |=> first_channel_drive == $past(hwdata[DRIVE_W-1:0]) && ctl[1][15:7] == 9'h000)
        else $error("first channel drive not updated");
    chk_second_drive: assert property (
        wr_fire && dsel == SEL_SECOND
        |=> second_channel_drive == $past(hwdata[DRIVE_W-1:0]))
        else $error("second channel drive not updated");
    chk_chan_b_off: assert property (
        wr_fire && dsel == SEL_UP && !hwdata[BIT_CHB_EN] |=> !second_channel_enable)
        else $error("second channel left on");
    chk_chan_a_off: assert property (
        wr_fire && dsel == SEL_UP && !hwdata[BIT_CHA_EN] |=> !first_channel_enable)
        else $error("first channel left on");
    chk_stop_pins: assert property (
        wr_fire && dsel == SEL_CLOCK
        |=> second_gen_stop_n == $past(hwdata[BIT_B_STOP])
            && first_gen_stop_n == $past(hwdata[BIT_A_STOP]))
        else $error("stop pins do not follow clock control");
    chk_pwrdn_pins: assert property (
        wr_fire && dsel == SEL_CLOCK
        |=> second_gen_powerdown_n == $past(hwdata[BIT_B_PWRDN])
            && first_gen_powerdown_n == $past(hwdata[BIT_A_PWRDN]))
        else $error("powerdown pins do not follow clock control");
    chk_ext_clock: assert property (
        wr_fire && dsel == SEL_CLOCK |=> external_clock_select == $past(hwdata[BIT_EXT_CLK]))
        else $error("external clock select not updated");
    chk_phase_read: assert property (
        rd_fire && dsel == SEL_CLOCK
        |=> hrdata[0] == $past(ph_sync) && hrdata[31:6] == 26'h0000000)
        else $error("phase bit or reserved bits wrong on read");
    chk_reserved_zero: assert property (
        rd_fire && dsel == SEL_UP |=> hrdata[15:11] == 5'h00 && hrdata[8:7] == 2'b00)
        else $error("reserved bits read nonzero");
    // skips the first reset edge: a reset applied at time zero may land only on it
    chk_reset_pins: assert property (disable iff (1'b0)
        !hresetn && $past(!hresetn) |-> !first_gen_powerdown_n && !second_gen_powerdown_n
                     && !first_channel_enable && !second_channel_enable && hreadyout)
        else $error("outputs not at defaults in reset");

    // read answers, and registers move only when written
    chk_mbox_clear: assert property (
        rd_fire && dsel == SEL_MAILBOX && !spd_read_done
        |=> !mb.status[BIT_RVALID])
        else $error("read flag not cleared");
    chk_mbox_upper: assert property (
        rd_fire && dsel == SEL_MAILBOX
        |=> hrdata[31:16] == 16'h0000 && hrdata[12:8] == 5'h00)
        else $error("mailbox reserved bits nonzero");
    chk_unmapped_read: assert property (
        rd_fire && dsel == SEL_NONE
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_enable_hold: assert property (
        !(wr_fire && dsel == SEL_UP)
        |=> $stable(ctl[0]))
        else $error("enables moved unwritten");
    chk_drive_hold: assert property (
        !(wr_fire && dsel == SEL_FIRST)
        |=> $stable(first_channel_drive))
        else $error("first drive moved unwritten");
    chk_second_hold: assert property (
        !(wr_fire && dsel == SEL_SECOND)
        |=> $stable(second_channel_drive))
        else $error("second drive moved unwritten");
    chk_clock_hold: assert property (
        !(wr_fire && dsel == SEL_CLOCK)
        |=> $stable(clk_ctl))
        else $error("clock control moved unwritten");

    cov_write_up:   cover property (wr_fire && dsel == SEL_UP ##2 addr_take);
    cov_mbox_valid: cover property (rd_fire && dsel == SEL_MAILBOX && mb.status[BIT_RVALID]);
    cov_clock_wr:   cover property (wr_fire && dsel == SEL_CLOCK && hwdata[BIT_EXT_CLK]);
    cov_set_clear:  cover property (mb.clr && spd_error);
    cov_mbox_write: cover property (mb.sw_we && spd_read_done);
endmodule

`default_nettype wire
